// ===== emb_cfg.svh
// named offsets, field positions, reset values and timing counts of the memory bus block
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH
// register offsets on the plain register port
`define EMB_OFS_CTL 4'h0
`define EMB_OFS_STAT 4'h1
// control register fields
`define EMB_BIT_DIS 7
`define EMB_WAIT_HI 5
`define EMB_WAIT_LO 4
`define EMB_WM_HI 1
`define EMB_WM_LO 0
`define EMB_CTL_RST 8'h00
`define EMB_CTL_WMASK 8'hB3
// status register fields
`define EMB_ST_OWN 7
`define EMB_ST_BUSY 6
`define EMB_ST_DISEFF 5
`define EMB_ST_HELD 4
// timing: core clock period and one instruction cycle, both in ns
`define EMB_CLK_NS 4
`define EMB_TCY_NS 16
`define EMB_TCY_CYC ((`EMB_TCY_NS + `EMB_CLK_NS - 1) / `EMB_CLK_NS)
// address width codes and line counts
`define EMB_LINES_BASE 5'h08
`define EMB_LINES_STEP 5'h04
`define EMB_NUM_LINES 20
`define EMB_NUM_SHARED 16
`define EMB_NUM_HI 4
`define EMB_NUM_CTRL 8
`endif

// ===== emb_pkg.sv
// types shared by the memory bus control block
package emb_pkg;
  // program memory mode straps
  typedef enum logic [1:0] {
    EMB_PMM_INTERNAL = 2'b00,
    EMB_PMM_EXTONLY = 2'b01,
    EMB_PMM_BOOT = 2'b10,
    EMB_PMM_EXTENDED = 2'b11
  } emb_pmm_t;
  // bus cycle sequencer states
  typedef enum logic [2:0] {
    EMB_ST_IDLE = 3'b000,
    EMB_ST_ADDR = 3'b001,
    EMB_ST_DATA = 3'b010,
    EMB_ST_WAIT = 3'b011,
    EMB_ST_DONE = 3'b100
  } emb_state_t;
  // control register layout
  typedef struct packed {
    logic dis;
    logic [1:0] wait_cnt;
    logic [1:0] wmode;
  } emb_ctl_t;
  // one external access asked for by the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [20:0] addr;
    logic [7:0] data;
  } emb_req_t;
endpackage : emb_pkg

// ===== emb_wait_timer.sv
// wait state down-counter for external bus cycles
`timescale 1ns/1ns
`include "emb_cfg.svh"
module emb_wait_timer import emb_pkg::*; #(
  parameter int UNIT_CYC = `EMB_TCY_CYC,
  parameter int CW = 8
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic LOAD,
  input wire logic [1:0] WAITS,
  input wire logic RUN,
  output logic DONE
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] unit;
  assign unit = CW'(UNIT_CYC);
  // load waits times one instruction cycle, then count down while running
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_reg <= '0;
    end else if (LOAD) begin
      cnt_reg <= CW'(unit * CW'(WAITS));
    end else if (RUN && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end
  assign DONE = (cnt_reg == '0);
endmodule : emb_wait_timer

// ===== emb_ctrl.sv
// external memory bus control, pin ownership and bus cycle sequencer
`timescale 1ns/1ns
`include "emb_cfg.svh"
module emb_ctrl import emb_pkg::*; #(
  parameter int TCY_CYC = `EMB_TCY_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire emb_pmm_t MEM_MODE,
  input wire logic BUS_16BIT,
  input wire logic [1:0] ADDR_WIDTH,
  input wire logic EXEC_EXTERNAL,
  input wire emb_req_t REQ,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  input wire logic [15:0] SHARED_IN,
  output logic [15:0] SHARED_OUT,
  output logic [15:0] SHARED_OE,
  output logic [3:0] HIADDR_OUT,
  output logic [3:0] HIADDR_OE,
  output logic ADDR_LATCH_STB,
  output logic OUT_ENABLE_N,
  output logic LOW_BYTE_WRITE_STROBE_N,
  output logic HIGH_BYTE_WRITE_STROBE_N,
  output logic BYTE_ADDRESS_LSB,
  output logic CHIP_SELECT_N,
  output logic LOWER_BYTE_SELECT_N,
  output logic UPPER_BYTE_SELECT_N,
  output logic [7:0] CTRL_OE,
  output logic [27:0] PIN_OWNED
);

  // ==========================================================
  // helpers
  // number of address lines the bus uses for a width code
  function automatic logic [4:0] lines_used(input logic [1:0] adw);
    lines_used = `EMB_LINES_BASE + 5'(`EMB_LINES_STEP * adw);
  endfunction : lines_used

  // field 11 waits none, 00 waits three: the count is the inverse
  function automatic logic [1:0] waits_of(input logic [1:0] fld);
    waits_of = ~fld;
  endfunction : waits_of

  // ==========================================================
  // declarations
  emb_ctl_t ctl_reg;
  emb_state_t state_reg;
  emb_state_t state_next;
  logic dis_eff_reg;
  logic [7:0] rdata_reg;
  logic [20:0] addr_reg;
  logic write_reg;
  logic [15:0] wdata_reg;
  logic [7:0] held_reg;
  logic held_valid_reg;
  logic [15:0] rsp_reg;
  logic [15:0] shared_out_reg;
  logic shared_drv_reg;
  logic ctl_write;
  logic take;
  logic hold_only;
  logic own_bus;
  logic busy;
  logic strobe_phase;
  logic wait_done;
  logic [4:0] nlines;
  logic [19:0] line_own;
  logic [15:0] wr_lanes;
  logic [15:0] addr_lines;
  logic [3:0] addr_hi;

  // ==========================================================
  // control register
  // writes are dropped while the part runs from internal memory only
  assign ctl_write = WR && (ADDR == `EMB_OFS_CTL) &&
                     (MEM_MODE != EMB_PMM_INTERNAL);

  // only disable, wait and write mode bits are implemented
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctl_reg <= emb_ctl_t'(5'h00);
    end else if (ctl_write) begin
      ctl_reg.dis <= WDATA[`EMB_BIT_DIS];
      ctl_reg.wait_cnt <= WDATA[`EMB_WAIT_HI:`EMB_WAIT_LO];
      ctl_reg.wmode <= WDATA[`EMB_WM_HI:`EMB_WM_LO];
    end
  end

  // read data stands in the cycle after the read strobe
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_reg <= `EMB_CTL_RST;
    end else if (RD) begin
      unique case (ADDR)
        `EMB_OFS_CTL: begin
          rdata_reg <= {ctl_reg.dis, 1'b0, ctl_reg.wait_cnt, 2'b00, ctl_reg.wmode};
        end
        `EMB_OFS_STAT: begin
          rdata_reg <= {own_bus, busy, dis_eff_reg, held_valid_reg, 4'h0};
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign RDATA = rdata_reg;

  // ==========================================================
  // effective disable bit
  // a set from external code waits until execution is internal, so
  // the pins are not yanked from under the fetch that wrote it
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dis_eff_reg <= 1'b0;
    end else begin
      dis_eff_reg <= ctl_reg.dis & (dis_eff_reg | ~EXEC_EXTERNAL);
    end
  end

  // ==========================================================
  // pin ownership
  assign busy = (state_reg != EMB_ST_IDLE);

  // external-only mode ignores the disable bit entirely
  always_comb begin
    unique case (MEM_MODE)
      EMB_PMM_INTERNAL: own_bus = 1'b0;
      EMB_PMM_EXTONLY: own_bus = 1'b1;
      default: own_bus = ~dis_eff_reg | busy;
    endcase
  end

  assign nlines = lines_used(ADDR_WIDTH);

  // lines beyond the address width stay with the ports for good
  genvar gi;
  generate
    for (gi = 0; gi < `EMB_NUM_LINES; gi++) begin : g_line
      assign line_own[gi] = own_bus && (5'(gi) < nlines);
    end
  endgenerate

  // lines first, then the eight control pins
  assign PIN_OWNED = {{`EMB_NUM_CTRL{own_bus}}, line_own};
  assign CTRL_OE = {`EMB_NUM_CTRL{own_bus}};

  // ==========================================================
  // request intake
  assign REQ_READY = (state_reg == EMB_ST_IDLE) && (MEM_MODE != EMB_PMM_INTERNAL);
  assign take = REQ.valid && REQ_READY;
  // word mode: the even byte is only held, the odd byte writes the word
  assign hold_only = REQ.write && BUS_16BIT && ctl_reg.wmode[1] && !REQ.addr[0];

  // write lanes: 8-bit puts the byte low, byte modes copy to both lanes
  always_comb begin
    if (!BUS_16BIT) begin
      wr_lanes = {8'h00, REQ.data};
    end else if (ctl_reg.wmode[1]) begin
      wr_lanes = {REQ.data, held_reg};
    end else begin
      wr_lanes = {REQ.data, REQ.data};
    end
  end

  // 16-bit width places a word address, bit zero goes out separately
  assign addr_lines = BUS_16BIT ? addr_reg[16:1] : addr_reg[15:0];
  assign addr_hi = BUS_16BIT ? addr_reg[20:17] : addr_reg[19:16];

  // request capture
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      addr_reg <= 21'h000000;
      write_reg <= 1'b0;
      wdata_reg <= 16'h0000;
    end else if (take) begin
      addr_reg <= REQ.addr;
      write_reg <= REQ.write;
      wdata_reg <= wr_lanes;
    end
  end

  // low byte of a word write is kept until its partner arrives
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      held_reg <= 8'h00;
      held_valid_reg <= 1'b0;
    end else if (take && hold_only) begin
      held_reg <= REQ.data;
      held_valid_reg <= 1'b1;
    end else if (take && REQ.write && BUS_16BIT && ctl_reg.wmode[1]) begin
      held_valid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // bus cycle sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EMB_ST_IDLE: begin
        if (take) begin
          state_next = hold_only ? EMB_ST_DONE : EMB_ST_ADDR;
        end
      end
      EMB_ST_ADDR: begin
        state_next = EMB_ST_DATA;
      end
      EMB_ST_DATA: begin
        state_next = wait_done ? EMB_ST_DONE : EMB_ST_WAIT;
      end
      EMB_ST_WAIT: begin
        if (wait_done) begin
          state_next = EMB_ST_DONE;
        end
      end
      EMB_ST_DONE: begin
        state_next = EMB_ST_IDLE;
      end
      default: begin
        state_next = EMB_ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= EMB_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // waits counted in whole instruction cycles after the base strobe
  emb_wait_timer #(
    .UNIT_CYC(TCY_CYC),
    .CW(8)
  ) u_wait (
    .CLK(CLK),
    .NRST(NRST),
    .LOAD(state_reg == EMB_ST_ADDR),
    .WAITS(waits_of(ctl_reg.wait_cnt)),
    .RUN(strobe_phase),
    .DONE(wait_done)
  );

  assign strobe_phase = (state_reg == EMB_ST_DATA) || (state_reg == EMB_ST_WAIT);

  // ==========================================================
  // shared lines: address first, then write data or released for read
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      shared_out_reg <= 16'h0000;
      shared_drv_reg <= 1'b0;
    end else if (state_next == EMB_ST_ADDR) begin
      shared_out_reg <= BUS_16BIT ? REQ.addr[16:1] : REQ.addr[15:0];
      shared_drv_reg <= 1'b1;
    end else if (state_next == EMB_ST_DATA) begin
      shared_out_reg <= wdata_reg;
      shared_drv_reg <= write_reg;
    end else if (state_next == EMB_ST_DONE || state_next == EMB_ST_IDLE) begin
      shared_out_reg <= addr_lines;
      shared_drv_reg <= 1'b0;
    end
  end

  assign SHARED_OUT = shared_out_reg;
  assign SHARED_OE = line_own[15:0] & {16{shared_drv_reg}};
  // high-order lines hold the address for the whole cycle
  assign HIADDR_OUT = addr_hi;
  assign HIADDR_OE = line_own[19:16] & {4{busy}};

  // read data are taken as the strobe ends
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rsp_reg <= 16'h0000;
    end else if (strobe_phase && state_next == EMB_ST_DONE && !write_reg) begin
      rsp_reg <= BUS_16BIT ? SHARED_IN : {8'h00, SHARED_IN[7:0]};
    end
  end
  assign RSP_DATA = rsp_reg;
  assign RSP_VALID = (state_reg == EMB_ST_DONE);

  // ==========================================================
  // control strobes, decoded from registered state and the BUS_16BIT strap
  assign ADDR_LATCH_STB = (state_reg == EMB_ST_ADDR);
  assign OUT_ENABLE_N = ~(strobe_phase && !write_reg);
  assign CHIP_SELECT_N = ~(busy && state_reg != EMB_ST_DONE);
  assign BYTE_ADDRESS_LSB = addr_reg[0];

  // low strobe: 8-bit writes, or byte write mode to an even byte
  assign LOW_BYTE_WRITE_STROBE_N = ~(strobe_phase && write_reg &&
    (!BUS_16BIT || (ctl_reg.wmode == 2'b00 && !addr_reg[0])));

  // high strobe: byte mode odd byte, byte select mode, word mode
  assign HIGH_BYTE_WRITE_STROBE_N = ~(strobe_phase && write_reg && BUS_16BIT &&
    (ctl_reg.wmode != 2'b00 || addr_reg[0]));

  // byte selects: in 16-bit width only byte select writes pick a single lane; 8-bit width selects the lower lane alone
  always_comb begin
    if (!strobe_phase) begin
      LOWER_BYTE_SELECT_N = 1'b1;
      UPPER_BYTE_SELECT_N = 1'b1;
    end else if (write_reg && BUS_16BIT && ctl_reg.wmode == 2'b01) begin
      LOWER_BYTE_SELECT_N = addr_reg[0];
      UPPER_BYTE_SELECT_N = ~addr_reg[0];
    end else begin
      LOWER_BYTE_SELECT_N = 1'b0;
      UPPER_BYTE_SELECT_N = ~BUS_16BIT;
    end
  end

endmodule : emb_ctrl

// ===== emb_ctrl_props.sv
// concurrent checks of bus cycle order, strobes and pin ownership
`timescale 1ns/1ns
module emb_ctrl_props import emb_pkg::*; #(
  parameter int TCY_CYC = 4
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire emb_pmm_t MEM_MODE,
  input wire logic BUS_16BIT,
  input wire emb_req_t REQ,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic [15:0] SHARED_OE,
  input wire logic ADDR_LATCH_STB,
  input wire logic OUT_ENABLE_N,
  input wire logic LOW_BYTE_WRITE_STROBE_N,
  input wire logic HIGH_BYTE_WRITE_STROBE_N,
  input wire logic CHIP_SELECT_N,
  input wire logic UPPER_BYTE_SELECT_N,
  input wire logic [27:0] PIN_OWNED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // =====================================
  // bus cycle steps
  sequence addr_phase_s;
    ADDR_LATCH_STB && !CHIP_SELECT_N;
  endsequence
  sequence read_phase_s;
    !ADDR_LATCH_STB && !OUT_ENABLE_N && !CHIP_SELECT_N;
  endsequence
  read_cycle_a: assert property (
    REQ.valid && REQ_READY && !REQ.write |=> addr_phase_s ##1 read_phase_s)
    else $error("read cycle steps out of order");
  ale_single_a: assert property (ADDR_LATCH_STB |=> !ADDR_LATCH_STB)
    else $error("latch strobe longer than one cycle");
  // the address must be on the lines and the pins owned while it is latched
  ale_drives_a: assert property (
    ADDR_LATCH_STB |-> SHARED_OE[7:0] == 8'hFF && &PIN_OWNED[27:20])
    else $error("address not driven at latch strobe");
  read_release_a: assert property (
    !OUT_ENABLE_N |-> SHARED_OE == 16'h0000 && LOW_BYTE_WRITE_STROBE_N
    && HIGH_BYTE_WRITE_STROBE_N) else $error("lines driven during read");
  strobe_cs_a: assert property (
    !LOW_BYTE_WRITE_STROBE_N || !HIGH_BYTE_WRITE_STROBE_N |-> !CHIP_SELECT_N
    && SHARED_OE[7:0] == 8'hFF && OUT_ENABLE_N) else $error("write strobe without select");
  wr_lane_a: assert property (
    !LOW_BYTE_WRITE_STROBE_N |-> HIGH_BYTE_WRITE_STROBE_N) else $error("both write strobes");
  rsp_single_a: assert property (
    RSP_VALID |=> !RSP_VALID && CHIP_SELECT_N) else $error("response not one cycle");
  extonly_owns_a: assert property (
    MEM_MODE == EMB_PMM_EXTONLY |-> &PIN_OWNED[27:20]) else $error("pins released");
  upper_idle_a: assert property (
    !BUS_16BIT |-> UPPER_BYTE_SELECT_N) else $error("upper select in 8-bit width");
endmodule : emb_ctrl_props

bind emb_ctrl emb_ctrl_props #(.TCY_CYC(TCY_CYC)) u_props (.CLK(CLK), .NRST(NRST),
  .MEM_MODE(MEM_MODE), .BUS_16BIT(BUS_16BIT), .REQ(REQ), .REQ_READY(REQ_READY),
  .RSP_VALID(RSP_VALID), .SHARED_OE(SHARED_OE), .ADDR_LATCH_STB(ADDR_LATCH_STB),
  .OUT_ENABLE_N(OUT_ENABLE_N), .LOW_BYTE_WRITE_STROBE_N(LOW_BYTE_WRITE_STROBE_N),
  .HIGH_BYTE_WRITE_STROBE_N(HIGH_BYTE_WRITE_STROBE_N), .CHIP_SELECT_N(CHIP_SELECT_N),
  .UPPER_BYTE_SELECT_N(UPPER_BYTE_SELECT_N), .PIN_OWNED(PIN_OWNED));

// ===== emb_mem_model.sv
// behavioural external parallel memory on the multiplexed bus lines
`timescale 1ns/1ns
module emb_mem_model (
  input wire logic clk,
  input wire logic word_wired,
  input wire logic [15:0] shared_out,
  input wire logic [3:0] hiaddr_out,
  input wire logic ale,
  input wire logic oe_n,
  input wire logic wrl_n,
  input wire logic wrh_n,
  input wire logic cs_n,
  input wire logic lb_n,
  input wire logic ub_n,
  output logic [15:0] shared_in
);
  logic [15:0] mem [256];
  logic [19:0] lat_addr = '0;
  logic [15:0] last_in = '0;
  logic [7:0] idx;
  assign idx = lat_addr[7:0];
  initial for (int i = 0; i < 256; i++) mem[i] = {i[7:0] ^ 8'h5A, ~i[7:0]};
  // word_wired: one 16-bit part with byte selects, else two byte parts on separate strobes
  always @(posedge clk) begin
    if (ale) lat_addr <= {hiaddr_out, shared_out};
    last_in <= shared_in;
    if (!cs_n && (!wrl_n || (word_wired && !wrh_n && !lb_n))) mem[idx][7:0] <= shared_out[7:0];
    if (!cs_n && !wrh_n && (!word_wired || !ub_n)) mem[idx][15:8] <= shared_out[15:8];
  end
  // released lines toggle so that stale read data can never pass for a match
  assign shared_in = (!oe_n && !cs_n) ? mem[idx] : ~last_in;
endmodule : emb_mem_model

// ===== tb.sv
// self-checking bench for the external memory bus control block
`timescale 1ns/1ns
module tb;
  import emb_pkg::*;
  localparam int TCY = 2;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  emb_pmm_t mem_mode = EMB_PMM_EXTENDED;
  logic bus16 = 1'b0;
  logic exec_ext = 1'b0;
  logic wired = 1'b0;
  emb_req_t req = '0;
  logic [7:0] rdata;
  logic [15:0] rsp_data, sh_in, sh_out, sh_oe;
  logic [3:0] hi_out;
  logic req_ready, rsp_valid, ale, oe_n, wrl_n, wrh_n, ba0, cs_n, lb_n, ub_n;
  logic [27:0] pin_owned;
  logic [7:0] ctrl_oe;
  logic [1:0] adw = 2'h3;
  logic [7:0] reg_q [$];
  logic [16:0] acc_q [$];
  logic [16:0] note;
  logic rd_d = 1'b0;
  int n_mismatch = 0;
  int total_checks = 0;
  int lat;
  logic [7:0] ra, d, d2;
  logic [8:0] a;
  logic [15:0] e;
  logic [8:0] wa [6] = '{9'h031, 9'h083, 9'h084, 9'h087, 9'h088, 9'h08A};
  logic [1:0] wm [6] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  logic wb [6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};

  always #2 clk = ~clk;

  emb_ctrl #(.TCY_CYC(TCY)) DUT (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .MEM_MODE(mem_mode), .BUS_16BIT(bus16),
    .ADDR_WIDTH(adw), .EXEC_EXTERNAL(exec_ext), .REQ(req), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .SHARED_IN(sh_in), .SHARED_OUT(sh_out),
    .SHARED_OE(sh_oe), .HIADDR_OUT(hi_out), .HIADDR_OE(), .ADDR_LATCH_STB(ale),
    .OUT_ENABLE_N(oe_n), .LOW_BYTE_WRITE_STROBE_N(wrl_n), .HIGH_BYTE_WRITE_STROBE_N(wrh_n),
    .BYTE_ADDRESS_LSB(ba0), .CHIP_SELECT_N(cs_n), .LOWER_BYTE_SELECT_N(lb_n),
    .UPPER_BYTE_SELECT_N(ub_n), .CTRL_OE(ctrl_oe), .PIN_OWNED(pin_owned));

  emb_mem_model u_mem (.clk(clk), .word_wired(wired), .shared_out(sh_out),
    .hiaddr_out(hi_out), .ale(ale), .oe_n(oe_n), .wrl_n(wrl_n), .wrh_n(wrh_n),
    .cs_n(cs_n), .lb_n(lb_n), .ub_n(ub_n), .shared_in(sh_in));

  // ===================
  // checking
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // oldest note is matched against each register answer and each read access response
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d && reg_q.size() > 0) chk(28'(rdata), 28'(reg_q.pop_front()));
    if (rsp_valid && acc_q.size() > 0) begin
      note = acc_q.pop_front();
      if (note[16]) chk(28'(rsp_data), 28'(note[15:0]));
    end
  end

  // ===================
  // drivers
  task automatic wr_reg(input logic [7:0] v);
    @(posedge clk);
    addr <= 4'h0;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] ix, input logic [7:0] x);
    @(posedge clk);
    addr <= ix;
    rd <= 1'b1;
    reg_q.push_back(x);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // request held until taken; latency counted from the take edge to the response
  task automatic access(input logic w, input logic [20:0] ad, input logic [7:0] dt,
      input logic [15:0] x, output int n);
    @(posedge clk);
    req <= emb_req_t'({1'b1, w, ad, dt});
    acc_q.push_back({!w, x});
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req.valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
  endtask : access

  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  // ===================
  // scenarios
  initial begin
    void'($urandom(29162));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(pin_owned, 28'hFFFFFFF);
    rd_reg(4'h0, 8'h00);
    rd_reg(4'h5, 8'h00);
    // running from external code, so every set of the disable bit is deferred
    exec_ext <= 1'b1;
    wr_reg(8'hFF);
    rd_reg(4'h0, 8'hB3);
    wr_reg(8'h80);
    repeat (2) @(posedge clk);
    chk(pin_owned, 28'hFFFFFFF);
    rd_reg(4'h1, 8'h80);
    exec_ext <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pin_owned, 28'h0000000);
    chk(28'(ctrl_oe), 28'h0000000);
    rd_reg(4'h1, 8'h20);
    access(1'b0, 21'h00010, 8'h00, {8'h00, ~8'h10}, lat);
    // the done cycle still counts as busy; pins come back at idle
    @(posedge clk);
    chk(pin_owned, 28'h0000000);
    mem_mode <= EMB_PMM_EXTONLY;
    repeat (2) @(posedge clk);
    chk(pin_owned, 28'hFFFFFFF);
    mem_mode <= EMB_PMM_INTERNAL;
    wr_reg(8'h00);
    mem_mode <= EMB_PMM_EXTENDED;
    rd_reg(4'h0, 8'h80);
    wr_reg(8'h00);
    repeat (2) @(posedge clk);
    chk(pin_owned, 28'hFFFFFFF);
    chk(28'(ctrl_oe), 28'h00000FF);
    // a 12-line address width leaves the upper eight lines to the ports
    adw <= 2'h1;
    @(posedge clk);
    chk(pin_owned, 28'hFF00FFF);
    adw <= 2'h3;
    // every wait code, each on a random address
    for (int w = 0; w < 4; w++) begin
      ra = 8'($urandom());
      wr_reg({2'h0, w[1:0], 4'h0});
      access(1'b0, {13'h0, ra}, 8'h00, {8'h00, ~ra}, lat);
      chk(28'(lat), 28'(3 + (3 - w) * TCY));
      chk(28'(ba0), 28'(ra[0]));
    end
    // write modes and widths, each read back through the memory
    for (int k = 0; k < 6; k++) begin
      a = wa[k];
      d = 8'($urandom());
      d2 = 8'($urandom());
      if (!wb[k]) e = {8'h00, d};
      else if (wm[k][1]) e = {d2, d};
      else if (a[0]) e = {d, ~a[8:1]};
      else e = {a[8:1] ^ 8'h5A, d};
      bus16 <= wb[k];
      wired <= wb[k] && (wm[k] != 2'h0);
      wr_reg({6'h0C, wm[k]});
      access(1'b1, {12'h0, a}, d, 16'h0000, lat);
      if (wb[k] && wm[k][1]) access(1'b1, {12'h0, a | 9'h001}, d2, 16'h0000, lat);
      access(1'b0, {12'h0, a}, 8'h00, e, lat);
    end
    tally_and_finish();
  end
endmodule : tb
